/* File: pcd_pkg.sv */
// Constants, field layout and types for the configuration access decoder.
// Assumes a 40-bit byte address from the link side and 32-bit config data.
package pcd_pkg;

  // Window selector patterns
  localparam logic [15:0] STD_TYPE0 = 16'hfdfe;
  localparam logic [15:0] STD_TYPE1 = 16'hfdff;
  localparam logic [11:0] RSV_TYPE0 = 12'hfe0;
  localparam logic [11:0] RSV_TYPE1 = 12'hfe1;

  // Address field positions
  localparam int STD_SEL_HI = 39;
  localparam int STD_SEL_LO = 24;
  localparam int RSV_SEL_LO = 28;
  localparam int RSV_OFF_HI = 27;
  localparam int BUS_HI = 23;
  localparam int BUS_LO = 16;
  localparam int DEV_HI = 15;
  localparam int DEV_LO = 11;
  localparam int FN_HI = 10;
  localparam int FN_LO = 8;
  localparam int OFF_HI = 7;

  localparam logic [7:0] BUS_ZERO = 8'h00;
  localparam logic [31:0] INVALID_RDATA = 32'h0fff_ffff;
  localparam logic [31:0] UNMAPPED_RDATA = 32'h0000_0000;

  // Local register window: addr[39:4] match, index in addr[3:2]
  localparam logic [35:0] REG_WIN = 36'h0_f000_0000;
  localparam logic [1:0] REG_VIS = 2'h0;
  localparam logic [1:0] REG_GMASK = 2'h1;
  localparam logic [1:0] REG_STAT = 2'h2;

  // Visibility control bit positions
  localparam int VIS_QUAD_X4 = 0;
  localparam int VIS_DUAL_X4 = 1;
  localparam int VIS_WIDE0_X8 = 2;
  localparam int VIS_WIDE1_X8 = 3;
  localparam int VIS_WIDE2_X8 = 4;
  localparam int VIS_HDA_SEL = 5;
  localparam int VIS_LPC_EN = 6;
  localparam int VIS_W = 7;
  localparam logic [VIS_W-1:0] VIS_RST = 7'h60;
  localparam logic [31:0] GMASK_RST = 32'hf000_0000;

  // Device numbers on bus 0
  localparam logic [4:0] DEV_LINK0 = 5'h00;
  localparam logic [4:0] DEV_LINK1 = 5'h01;
  localparam logic [4:0] DEV_MAC = 5'h03;
  localparam logic [4:0] DEV_USB0 = 5'h04;
  localparam logic [4:0] DEV_USB1 = 5'h05;
  localparam logic [4:0] DEV_GPU = 5'h06;
  localparam logic [4:0] DEV_AUDIO = 5'h07;
  localparam logic [4:0] DEV_SATA = 5'h08;
  localparam logic [4:0] DEV_QUAD_P0 = 5'h09;
  localparam logic [4:0] DEV_QUAD_P3 = 5'h0c;
  localparam logic [4:0] DEV_DUAL_P0 = 5'h0d;
  localparam logic [4:0] DEV_DUAL_P1 = 5'h0e;
  localparam logic [4:0] DEV_WIDE0_P0 = 5'h0f;
  localparam logic [4:0] DEV_WIDE0_P1 = 5'h10;
  localparam logic [4:0] DEV_WIDE1_P0 = 5'h11;
  localparam logic [4:0] DEV_WIDE1_P1 = 5'h12;
  localparam logic [4:0] DEV_WIDE2_P0 = 5'h13;
  localparam logic [4:0] DEV_WIDE2_P1 = 5'h14;
  localparam logic [4:0] DEV_SPI = 5'h16;
  localparam logic [4:0] DEV_LPC = 5'h17;
  localparam logic [2:0] FN_0 = 3'h0;
  localparam logic [2:0] FN_1 = 3'h1;
  localparam logic [2:0] FN_2 = 3'h2;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_DONE = 3'b100
  } pcd_state_e;

  typedef struct packed {
    logic cfg;
    logic type1;
    logic rsv;
    logic [7:0] bus;
    logic [4:0] dev;
    logic [2:0] fn;
    logic [11:0] off;
  } pcd_dec_s;

endpackage : pcd_pkg

/* File: pcd_fn_map.sv */
// Visibility map of the internal functions on bus 0.
// Assumes mode controls are stable while an access is decoded.
`timescale 1ns/1ps
module pcd_fn_map
  import pcd_pkg::*;
(
  // Target
  input wire logic [4:0] dev,
  input wire logic [2:0] fn,
  // Mode controls
  input wire logic [VIS_W-1:0] vis,
  // Result
  output logic hit
);

  always_comb
  begin
    hit = 1'b0;
    case (dev)
      DEV_LINK0, DEV_LINK1: hit = (fn == FN_0);
      DEV_MAC, DEV_USB0, DEV_USB1, DEV_GPU: hit = (fn <= FN_1);
      DEV_AUDIO:
      begin
        if (vis[VIS_HDA_SEL])
          hit = (fn == FN_0);
        else
          hit = (fn == FN_1);
      end
      DEV_SATA: hit = (fn <= FN_2);
      DEV_QUAD_P0: hit = (fn == FN_0);
      DEV_DUAL_P0, DEV_WIDE0_P0, DEV_WIDE1_P0, DEV_WIDE2_P0, DEV_SPI: hit = (fn == FN_0);
      DEV_DUAL_P1: hit = (fn == FN_0) && !vis[VIS_DUAL_X4];
      DEV_WIDE0_P1: hit = (fn == FN_0) && !vis[VIS_WIDE0_X8];
      DEV_WIDE1_P1: hit = (fn == FN_0) && !vis[VIS_WIDE1_X8];
      DEV_WIDE2_P1: hit = (fn == FN_0) && !vis[VIS_WIDE2_X8];
      DEV_LPC: hit = (fn == FN_0) && vis[VIS_LPC_EN];
      default:
      begin
        // Ports 1..3 of the quad group share one x4 switch
        if (dev > DEV_QUAD_P0 && dev <= DEV_QUAD_P3)
          hit = (fn == FN_0) && !vis[VIS_QUAD_X4];
      end
    endcase
  end

endmodule : pcd_fn_map

/* File: pcd_cfg_decoder.sv */
// Configuration access decoder: link-side accesses to bus/dev/fn/offset.
// Assumes an Avalon-MM master on clk and function headers answering
// cfg_req with a one-cycle cfg_ack on the same clock.
//
// Functional notes
// - Standard window top field picks Type0/Type1
// - Bus, device, function fields; low offset byte
// - Standard window reaches 256 bytes per function
// - Reserved window: 12-bit type, split offset
// - Reserved window reaches 4K bytes per function
// - Invalid target: drop write, read fixed pattern
// - Devices 0 and 1 are link controllers
// - Ethernet at 3, USB hosts at 4, 5
// - Graphics 6, audio 7, SATA 8 functions
// - PCIE ports 9..20, SPI 22, LPC 23
// - Audio select picks HDA or legacy function
// - Quad group x4 hides ports 1..3
// - Dual group x4 hides port 1
// - Wide groups x8 hide port 1
// - LPC header visible only when enabled
// - Fixed BAR sizes except software windows
`timescale 1ns/1ps
module pcd_cfg_decoder
  import pcd_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [39:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Function header port
  output logic cfg_req,
  output logic cfg_we,
  output logic [4:0] cfg_dev,
  output logic [2:0] cfg_fn,
  output logic [11:0] cfg_offset,
  output logic [31:0] cfg_wdata,
  output logic [3:0] cfg_be,
  input wire logic cfg_ack,
  input wire logic [31:0] cfg_rdata,
  // Graphics BAR 2/3 size mask
  output logic [31:0] graphics_memory_size_mask
);

  typedef struct packed {
    pcd_state_e state;
    logic waitreq;
    logic [31:0] rdata;
    logic req;
    logic we;
    logic [4:0] dev;
    logic [2:0] fn;
    logic [11:0] off;
    logic [31:0] wdata;
    logic [3:0] be;
    logic [VIS_W-1:0] vis;
    logic [31:0] gmask;
    logic last_invalid;
    logic last_type1;
    logic last_rsv;
  } pcd_regs_s;

  localparam pcd_regs_s REGS_RST = '{
    state: ST_IDLE,
    waitreq: 1'b1,
    rdata: 32'h0000_0000,
    req: 1'b0,
    we: 1'b0,
    dev: 5'h00,
    fn: 3'h0,
    off: 12'h000,
    wdata: 32'h0000_0000,
    be: 4'h0,
    vis: VIS_RST,
    gmask: GMASK_RST,
    last_invalid: 1'b0,
    last_type1: 1'b0,
    last_rsv: 1'b0
  };

  pcd_regs_s s_r;
  pcd_regs_s s_nxt;
  pcd_dec_s dec;
  logic hit;
  logic valid;
  logic reg_sel;

  // Split a link address into window, type and target fields
  function automatic pcd_dec_s cfg_decode(input logic [39:0] a);
    pcd_dec_s d;
    d.cfg = 1'b0;
    d.type1 = 1'b0;
    d.rsv = 1'b0;
    d.bus = a[BUS_HI:BUS_LO];
    d.dev = a[DEV_HI:DEV_LO];
    d.fn = a[FN_HI:FN_LO];
    d.off = {4'h0, a[OFF_HI:0]};
    if (a[STD_SEL_HI:STD_SEL_LO] == STD_TYPE0 || a[STD_SEL_HI:STD_SEL_LO] == STD_TYPE1)
    begin
      d.cfg = 1'b1;
      d.type1 = (a[STD_SEL_HI:STD_SEL_LO] == STD_TYPE1);
    end
    else if (a[STD_SEL_HI:RSV_SEL_LO] == RSV_TYPE0 || a[STD_SEL_HI:RSV_SEL_LO] == RSV_TYPE1)
    begin
      d.cfg = 1'b1;
      d.rsv = 1'b1;
      d.type1 = (a[STD_SEL_HI:RSV_SEL_LO] == RSV_TYPE1);
      d.off = {a[RSV_OFF_HI:RSV_SEL_LO - 4], a[OFF_HI:0]};
    end
    return d;
  endfunction : cfg_decode

  // Byte-lane merge for local register writes
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
        r[i*8 +: 8] = wd[i*8 +: 8];
    end
    return r;
  endfunction : be_merge

  assign dec = cfg_decode(avs_address);
  assign reg_sel = (avs_address[39:4] == REG_WIN);

  pcd_fn_map u_fn_map (
    .dev(dec.dev),
    .fn(dec.fn),
    .vis(s_r.vis),
    .hit(hit)
  );

  // Type1 reaches bus 0 only; Type0 never looks at the bus field
  assign valid = dec.cfg && hit && (!dec.type1 || dec.bus == BUS_ZERO);

  always_comb
  begin
    logic [31:0] vis_word;
    vis_word = be_merge({{(32 - VIS_W){1'b0}}, s_r.vis}, avs_writedata, avs_byteenable);
    s_nxt = s_r;
    s_nxt.req = 1'b0;
    s_nxt.waitreq = 1'b1;
    case (s_r.state)
      ST_IDLE:
      begin
        if (avs_read || avs_write)
        begin
          s_nxt.rdata = UNMAPPED_RDATA;
          s_nxt.waitreq = 1'b0;
          s_nxt.state = ST_DONE;
          if (dec.cfg)
          begin
            s_nxt.last_invalid = !valid;
            s_nxt.last_type1 = dec.type1;
            s_nxt.last_rsv = dec.rsv;
            s_nxt.dev = dec.dev;
            s_nxt.fn = dec.fn;
            s_nxt.off = dec.off;
            if (valid)
            begin
              s_nxt.req = 1'b1;
              s_nxt.we = avs_write;
              s_nxt.wdata = avs_writedata;
              s_nxt.be = avs_byteenable;
              s_nxt.waitreq = 1'b1;
              s_nxt.state = ST_WAIT;
            end
            else if (avs_read)
              s_nxt.rdata = INVALID_RDATA;
          end
          else if (reg_sel)
          begin
            case (avs_address[3:2])
              REG_VIS:
              begin
                if (avs_write)
                  s_nxt.vis = vis_word[VIS_W-1:0];
                else
                  s_nxt.rdata = {{(32 - VIS_W){1'b0}}, s_r.vis};
              end
              REG_GMASK:
              begin
                if (avs_write)
                  s_nxt.gmask = be_merge(s_r.gmask, avs_writedata, avs_byteenable);
                else
                  s_nxt.rdata = s_r.gmask;
              end
              REG_STAT:
              begin
                if (avs_read)
                  s_nxt.rdata = {9'h000, s_r.last_invalid, s_r.last_type1, s_r.last_rsv,
                                 s_r.dev, s_r.fn, s_r.off};
              end
              default:
              begin
                s_nxt.rdata = UNMAPPED_RDATA;
              end
            endcase
          end
        end
      end
      ST_WAIT:
      begin
        if (cfg_ack)
        begin
          s_nxt.rdata = s_r.we ? UNMAPPED_RDATA : cfg_rdata;
          s_nxt.waitreq = 1'b0;
          s_nxt.state = ST_DONE;
        end
      end
      ST_DONE:
      begin
        // Master releases the request at this edge
        s_nxt.state = ST_IDLE;
      end
      default:
      begin
        s_nxt.state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      s_r <= REGS_RST;
    else
      s_r <= s_nxt;
  end

  assign avs_readdata = s_r.rdata;
  assign avs_waitrequest = s_r.waitreq;
  assign cfg_req = s_r.req;
  assign cfg_we = s_r.we;
  assign cfg_dev = s_r.dev;
  assign cfg_fn = s_r.fn;
  assign cfg_offset = s_r.off;
  assign cfg_wdata = s_r.wdata;
  assign cfg_be = s_r.be;
  // Only the graphics window size is software-set; other BARs stay fixed
  assign graphics_memory_size_mask = s_r.gmask;

endmodule : pcd_cfg_decoder

/* File: pcd_cfg_decoder_assertions.sv */
// Port checker for the configuration access decoder.
// Assumes the master leaves one idle cycle between requests.
`timescale 1ns/1ps
module pcd_cfg_decoder_assertions
  import pcd_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [39:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Function header port
  input wire logic cfg_req,
  input wire logic cfg_we,
  input wire logic [4:0] cfg_dev,
  input wire logic [2:0] cfg_fn,
  input wire logic [11:0] cfg_offset,
  input wire logic cfg_ack,
  input wire logic [31:0] cfg_rdata,
  input wire logic [31:0] graphics_memory_size_mask
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  wire logic rq = avs_read | avs_write;
  wire logic [15:0] top = avs_address[39:24];
  wire logic [4:0] dv = avs_address[15:11];
  // Devices with no header on bus 0, whatever the modes
  wire logic bad = top == STD_TYPE0 && (dv == 5'h02 || dv == 5'h15 || dv > 5'h17);
  wire logic t1bad = top == STD_TYPE1 && avs_address[23:16] != BUS_ZERO;
  property p_std;
    $rose(rq) && top == STD_TYPE0 && dv == DEV_LINK0 && avs_address[10:8] == FN_0
      |=> cfg_req && cfg_dev == dv && cfg_fn == FN_0 && cfg_offset == {4'h0, avs_address[7:0]};
  endproperty
  a_std: assert property (p_std) else $error("standard window target wrong");
  property p_rsv;
    $rose(rq) && avs_address[39:28] == RSV_TYPE0 && dv == DEV_LINK1 && avs_address[10:8] == FN_0
      |=> cfg_req && cfg_dev == DEV_LINK1 && cfg_offset == {avs_address[27:24], avs_address[7:0]};
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved window target wrong");
  property p_inv;
    $rose(rq) && (bad || t1bad)
      |=> !cfg_req && !avs_waitrequest && (avs_write || avs_readdata == INVALID_RDATA);
  endproperty
  a_inv: assert property (p_inv) else $error("invalid target not refused");
  property p_ack;
    cfg_ack |=> !avs_waitrequest;
  endproperty
  a_ack: assert property (p_ack) else $error("answer not given after ack");
  property p_rd;
    cfg_ack && !cfg_we |=> avs_readdata == $past(cfg_rdata);
  endproperty
  a_rd: assert property (p_rd) else $error("header data not returned");
  property p_one;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_one: assert property (p_one) else $error("answer longer than one cycle");
  property p_pulse;
    cfg_req |=> !cfg_req;
  endproperty
  a_pulse: assert property (p_pulse) else $error("forward request not a pulse");
  property p_mask;
    !$stable(graphics_memory_size_mask) |-> $past(avs_write) && $past(avs_address) == {REG_WIN, REG_GMASK, 2'h0};
  endproperty
  a_mask: assert property (p_mask) else $error("size mask changed without write");
endmodule : pcd_cfg_decoder_assertions

bind pcd_cfg_decoder pcd_cfg_decoder_assertions u_chk (.clk, .rst_n, .avs_address, .avs_read, .avs_write,
  .avs_readdata, .avs_waitrequest, .cfg_req, .cfg_we, .cfg_dev, .cfg_fn, .cfg_offset, .cfg_ack, .cfg_rdata,
  .graphics_memory_size_mask);

/* File: pcd_hdr_model.sv */
// Stand-in for the function headers: acks each forwarded access lat+1 cycles after its cfg_req pulse.
// Assumes one outstanding access, as the decoder guarantees.
`timescale 1ns/1ps
module pcd_hdr_model
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Request
  input wire logic cfg_req,
  input wire logic [4:0] cfg_dev,
  input wire logic [2:0] cfg_fn,
  input wire logic [11:0] cfg_offset,
  input wire logic [3:0] lat,
  // Answer
  output logic cfg_ack,
  output logic [31:0] cfg_rdata
);
  logic pend_r;
  logic [3:0] cnt_r;
  logic [31:0] val;
  assign val = {12'ha50, cfg_dev, cfg_fn, cfg_offset};
  assign cfg_ack = pend_r && cnt_r == 4'h0;
  // Data is wrong outside the ack so a late sample shows up
  assign cfg_rdata = cfg_ack ? val : ~val;
  always_ff @(posedge clk)
  begin
    if (!rst_n || cfg_ack)
      pend_r <= 1'b0;
    else if (cfg_req)
    begin
      pend_r <= 1'b1;
      cnt_r <= lat;
    end
    else if (pend_r)
      cnt_r <= cnt_r - 4'h1;
  end
endmodule : pcd_hdr_model

/* File: pcd_cfg_decoder_bench.sv */
// Self-checking bench for the configuration access decoder.
// Assumes the header stand-in model and the bound port checker.
`timescale 1ns/1ps
module pcd_cfg_decoder_bench
  import pcd_pkg::*;
;
  typedef struct packed {logic [4:0] d; logic [2:0] f; logic ok;} pcd_row_s;
  localparam logic [39:0] A_VIS = {REG_WIN, REG_VIS, 2'h0};
  localparam logic [39:0] A_GM = {REG_WIN, REG_GMASK, 2'h0};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [39:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [3:0] lat = 4'h0;
  logic [31:0] avs_readdata, cfg_wdata, cfg_rdata, graphics_memory_size_mask, q;
  logic avs_waitrequest, cfg_req, cfg_we, cfg_ack;
  logic [4:0] cfg_dev;
  logic [2:0] cfg_fn;
  logic [11:0] cfg_offset;
  logic [3:0] cfg_be;
  int n_mismatch = 0;
  int n_checks = 0;
  // Rows from 21 on run with all x4/x8 lane modes set, legacy audio, no LPC
  pcd_row_s rows[34] = '{'{5'd0,3'd0,1'b1}, '{5'd1,3'd0,1'b1}, '{5'd2,3'd0,1'b0}, '{5'd3,3'd1,1'b1},
    '{5'd4,3'd1,1'b1}, '{5'd5,3'd0,1'b1}, '{5'd6,3'd1,1'b1}, '{5'd7,3'd0,1'b1}, '{5'd7,3'd1,1'b0},
    '{5'd8,3'd2,1'b1}, '{5'd8,3'd3,1'b0}, '{5'd10,3'd0,1'b1}, '{5'd12,3'd0,1'b1}, '{5'd14,3'd0,1'b1},
    '{5'd16,3'd0,1'b1}, '{5'd18,3'd0,1'b1}, '{5'd20,3'd0,1'b1}, '{5'd21,3'd0,1'b0}, '{5'd22,3'd0,1'b1},
    '{5'd23,3'd0,1'b1}, '{5'd24,3'd0,1'b0}, '{5'd9,3'd0,1'b1}, '{5'd10,3'd0,1'b0}, '{5'd12,3'd0,1'b0},
    '{5'd13,3'd0,1'b1}, '{5'd14,3'd0,1'b0}, '{5'd15,3'd0,1'b1}, '{5'd16,3'd0,1'b0}, '{5'd18,3'd0,1'b0},
    '{5'd20,3'd0,1'b0}, '{5'd19,3'd0,1'b1}, '{5'd7,3'd0,1'b0}, '{5'd7,3'd1,1'b1}, '{5'd23,3'd0,1'b0}};

  pcd_cfg_decoder uut (.clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest, .cfg_req, .cfg_we, .cfg_dev, .cfg_fn, .cfg_offset, .cfg_wdata, .cfg_be,
    .cfg_ack, .cfg_rdata, .graphics_memory_size_mask);
  pcd_hdr_model hdr (.clk, .rst_n, .cfg_req, .cfg_dev, .cfg_fn, .cfg_offset, .lat, .cfg_ack, .cfg_rdata);

  always #4 clk = ~clk;

  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One access; holds it until waitrequest is seen low, then one idle cycle
  task automatic bus(input logic w, input logic [39:0] a, input logic [31:0] d, input logic [3:0] be);
    int k;
    k = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_read <= !w;
    avs_write <= w;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (avs_waitrequest !== 1'b0 && k < 200);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (avs_waitrequest !== 1'b0)
    begin
      n_mismatch++;
      print_verdict();
    end
    @(posedge clk);
  endtask : bus

  function automatic logic [39:0] sa(logic [15:0] t, logic [7:0] b, logic [4:0] d, logic [2:0] f, logic [7:0] o);
    return {t, b, d, f, o};
  endfunction : sa

  function automatic logic [31:0] ex(logic [4:0] d, logic [2:0] f, logic [11:0] o);
    return {12'ha50, d, f, o};
  endfunction : ex

  initial
  begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    bus(0, A_VIS, 0, 4'hf);
    check(q, {25'h0, VIS_RST});
    foreach (rows[i])
    begin
      if (i == 21)
        bus(1, A_VIS, 32'h0000_001f, 4'hf);
      bus(0, sa(STD_TYPE0, 8'h00, rows[i].d, rows[i].f, 8'(i * 4)), 0, 4'hf);
      check(q, rows[i].ok ? ex(rows[i].d, rows[i].f, 12'(i * 4)) : INVALID_RDATA);
    end
    $display("Test function map done");
    lat <= 4'h5;
    bus(0, sa(STD_TYPE0, 8'h05, DEV_LINK0, FN_0, 8'hfc), 0, 4'hf);
    check(q, ex(DEV_LINK0, FN_0, 12'h0fc));
    bus(0, sa(STD_TYPE1, 8'h00, DEV_SPI, FN_0, 8'h10), 0, 4'hf);
    check(q, ex(DEV_SPI, FN_0, 12'h010));
    bus(0, sa(STD_TYPE1, 8'h01, DEV_LINK0, FN_0, 8'h10), 0, 4'hf);
    check(q, INVALID_RDATA);
    bus(0, {RSV_TYPE0, 4'hf, 8'h00, DEV_LINK1, FN_0, 8'hfc}, 0, 4'hf);
    check(q, ex(DEV_LINK1, FN_0, 12'hffc));
    bus(0, {RSV_TYPE1, 4'h1, 8'h02, DEV_LINK1, FN_0, 8'h00}, 0, 4'hf);
    check(q, INVALID_RDATA);
    // Status holds the refused reserved Type1 access just made
    bus(0, {REG_WIN, REG_STAT, 2'h0}, 0, 4'hf);
    check(q, {9'h000, 3'b111, DEV_LINK1, FN_0, 12'h100});
    $display("Test windows done");
    lat <= 4'h0;
    bus(1, sa(STD_TYPE0, 8'h00, DEV_GPU, FN_1, 8'h44), 32'hcafe_0123, 4'h6);
    check({cfg_we, cfg_be, cfg_offset}, {1'b1, 4'h6, 12'h044});
    check(q, UNMAPPED_RDATA);
    bus(1, sa(STD_TYPE0, 8'h00, 5'h02, FN_0, 8'h00), 32'h0000_0001, 4'hf);
    check(cfg_wdata, 32'hcafe_0123);
    bus(1, A_GM, 32'h1234_5678, 4'h3);
    check(graphics_memory_size_mask, 32'hf000_5678);
    bus(0, 40'h00_1000_0000, 0, 4'hf);
    check(q, UNMAPPED_RDATA);
    $display("Test writes done");
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    check({avs_waitrequest, cfg_req}, 2'b10);
    check(graphics_memory_size_mask, GMASK_RST);
    bus(0, A_VIS, 0, 4'hf);
    check(q, {25'h0, VIS_RST});
    $display("Test reset done");
    print_verdict();
  end
endmodule : pcd_cfg_decoder_bench
